// ---- verilog/serial_irq_pkg.sv ----
// Purpose: Constants for the serial port event flags and interrupt mask word
// Assumes: One 32-bit word, flags in the upper half, masks in the lower half
// Notes: Mask bit k pairs with flag bit k+16
package serial_irq_pkg;
   // Register location
   localparam logic [6:0] REG_ADDR = 7'h28;
   localparam int REG_ROW = 20;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;
   // Flag half starts here
   localparam int FLAG_LSB = 16;
   // Flag positions within the upper half
   localparam int F_SPI_RX_OVR = 14;
   localparam int F_SPI_TX_UND = 13;
   localparam int F_SPI_CRC = 12;
   localparam int F_WR_ADDR = 11;
   localparam int F_RD_ADDR = 10;
   localparam int F_SPI_TX_EMPTY = 9;
   localparam int F_SPI_RX_FULL = 8;
   localparam int F_UART_TX_OVR = 6;
   localparam int F_UART_RX_OVR = 5;
   localparam int F_UART_NOISE = 4;
   localparam int F_UART_FRAME = 3;
   localparam int F_UART_TIMEOUT = 2;
   localparam int F_UART_CRC = 1;
   localparam int F_UART_BREAK = 0;
   // Field layouts
   localparam logic [15:0] FLAG_RW_BITS = 16'h7C7F;
   localparam logic [15:0] FLAG_RO_BITS = 16'h0300;
   localparam logic [15:0] MASK_RW_BITS = 16'h7F7E;
   // Reset values
   localparam logic [15:0] FLAG_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [31:0] RD_RESET = 32'h00000000;
endpackage

// ---- verilog/serial_port_event_irq.sv ----
// Purpose: Sticky serial port event flags, per-event mask, two interrupt pins
// Assumes: Event inputs are one-cycle pulses or levels from logic on clk_i
// Notes: A write to the word clears every flag written with a one whose event is not asserted in the same cycle
//
// Contract
// RULE1: Flags and masks share word at 0x28
// RULE2: Unmasked set flag drives both interrupt pins
// RULE3: SPI receive overrun sets bit 30
// RULE4: SPI transmit underrun sets bit 29
// RULE5: CRC errors set bits 28 and 17
// RULE6: Write address error sets bit 27
// RULE7: Read address error sets bit 26
// RULE8: Bits 25, 24 show SPI buffer levels
// RULE9: UART transmit overrun sets bit 22
// RULE10: UART receive overrun sets bit 21
// RULE11: Noise sets bit 20, framing bit 19
// RULE12: UART timeout sets bit 18
// RULE13: UART break frame sets bit 16
// RULE14: Flags stay set until master clears
// RULE15: Write to 0x28 clears the flags
// RULE16: Masks 14..8 and 6..1, reset zero
// RULE17: Interrupt is OR of flag AND mask
`timescale 1ns/1ps
module serial_port_event_irq (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register write port
   input wire logic wr_en_i,
   input wire logic [serial_irq_pkg::ADDR_W-1:0] wr_addr_i,
   input wire logic [serial_irq_pkg::DATA_W-1:0] wr_data_i,
   // Register read port
   input wire logic rd_en_i,
   input wire logic [serial_irq_pkg::ADDR_W-1:0] rd_addr_i,
   output logic [serial_irq_pkg::DATA_W-1:0] rd_data_o,
   output logic rd_valid_o,
   // SPI events
   input wire logic spi_rx_overrun_i,
   input wire logic spi_tx_underrun_i,
   input wire logic spi_crc_err_i,
   input wire logic spi_wr_addr_err_i,
   input wire logic spi_rd_addr_err_i,
   input wire logic spi_tx_empty_i,
   input wire logic spi_rx_full_i,
   // UART events
   input wire logic uart_wr_addr_err_i,
   input wire logic uart_rd_addr_err_i,
   input wire logic uart_tx_overrun_i,
   input wire logic uart_rx_overrun_i,
   input wire logic uart_noise_i,
   input wire logic uart_frame_i,
   input wire logic uart_timeout_i,
   input wire logic uart_crc_err_i,
   input wire logic uart_break_i,
   // Interrupt pins
   output logic irq_out_a_o,
   output logic irq_out_b_o
);
   import serial_irq_pkg::*;

   logic [15:0] flags;
   logic [15:0] mask;
   logic irq;
   logic [15:0] event_hi;
   logic [15:0] ro_hi;
   logic [15:0] status;
   logic [15:0] clr;
   logic [15:0] next_flags;
   logic [15:0] next_mask;
   logic wr_hit;
   logic rd_hit;
   logic next_irq;
   logic [31:0] next_rd_data;
   logic ev_spi_rx_ovr;
   logic ev_spi_tx_und;
   logic ev_spi_crc;
   logic ev_uart_crc;
   logic ev_wr_addr;
   logic ev_rd_addr;
   logic ev_uart_tx_ovr;
   logic ev_uart_rx_ovr;
   logic ev_uart_noise;
   logic ev_uart_frame;
   logic ev_uart_timeout;
   logic ev_uart_break;

   // RULE3: SPI receive overrun event
   assign ev_spi_rx_ovr = spi_rx_overrun_i;

   // RULE4: SPI transmit underrun event
   assign ev_spi_tx_und = spi_tx_underrun_i;

   // RULE5: CRC error events
   assign ev_spi_crc = spi_crc_err_i;
   assign ev_uart_crc = uart_crc_err_i;

   // RULE6: write address error, either port
   assign ev_wr_addr = spi_wr_addr_err_i | uart_wr_addr_err_i;

   // RULE7: read address error, either port
   assign ev_rd_addr = spi_rd_addr_err_i | uart_rd_addr_err_i;

   // RULE9: UART transmit overrun event
   assign ev_uart_tx_ovr = uart_tx_overrun_i;

   // RULE10: UART receive overrun event
   assign ev_uart_rx_ovr = uart_rx_overrun_i;

   // RULE11: noise and framing events
   assign ev_uart_noise = uart_noise_i;
   assign ev_uart_frame = uart_frame_i;

   // RULE12: UART timeout event
   assign ev_uart_timeout = uart_timeout_i;

   // RULE13: UART break event
   assign ev_uart_break = uart_break_i;

   // Event word in flag order
   assign event_hi = {1'b0,
                      ev_spi_rx_ovr,
                      ev_spi_tx_und,
                      ev_spi_crc,
                      ev_wr_addr,
                      ev_rd_addr,
                      2'b00,
                      1'b0,
                      ev_uart_tx_ovr,
                      ev_uart_rx_ovr,
                      ev_uart_noise,
                      ev_uart_frame,
                      ev_uart_timeout,
                      ev_uart_crc,
                      ev_uart_break};

   // RULE8: live buffer levels
   assign ro_hi = {6'b000000, spi_tx_empty_i, spi_rx_full_i, 8'h00};

   assign status = (flags & FLAG_RW_BITS) | (ro_hi & FLAG_RO_BITS);

   // RULE1: address decode
   assign wr_hit = wr_en_i && (wr_addr_i == REG_ADDR);
   assign rd_hit = rd_en_i && (rd_addr_i == REG_ADDR);

   // RULE15: write-one clears flags
   assign clr = wr_hit ? wr_data_i[DATA_W-1:FLAG_LSB] : 16'h0000;

   // RULE14: sticky per bit, set beats clear
   genvar b;
   generate
      for (b = 0; b < HALF_W; b++) begin : g_flag
         assign next_flags[b] = FLAG_RW_BITS[b] & (event_hi[b] | (flags[b] & ~clr[b]));
      end
   endgenerate

   // RULE16: writable mask bits only
   assign next_mask = wr_hit ? (wr_data_i[HALF_W-1:0] & MASK_RW_BITS) : mask;

   // RULE17: OR of status AND mask
   assign next_irq = |(status & mask);

   // RULE1: read word layout
   assign next_rd_data = rd_hit ? {status, mask} : 32'h00000000;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags <= FLAG_RESET;
         mask <= MASK_RESET;
      end else begin
         flags <= next_flags;
         mask <= next_mask;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq <= 1'b0;
         rd_data_o <= RD_RESET;
         rd_valid_o <= 1'b0;
      end else begin
         irq <= next_irq;
         rd_data_o <= next_rd_data;
         rd_valid_o <= rd_en_i;
      end
   end

   // RULE2: both pins together
   assign irq_out_a_o = irq;
   assign irq_out_b_o = irq;

   // RULE1: read returns word
   a_read_word: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
      rd_hit |=> rd_valid_o && rd_data_o == {$past(status), $past(mask)})
      else $error("read word mismatch");

   // RULE2: pins follow cause
   a_irq_pins: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
      (|(status & mask)) |=> irq_out_a_o && irq_out_b_o)
      else $error("interrupt pins not raised");

   // RULE3: overrun reaches bit
   a_spi_rx_ovr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
      spi_rx_overrun_i ##1 rd_hit |=> rd_data_o[30])
      else $error("SPI receive overrun not shown");

   // RULE4: underrun reaches bit
   a_spi_tx_und: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE4
      spi_tx_underrun_i |=> flags[F_SPI_TX_UND])
      else $error("SPI transmit underrun not latched");

   // RULE5: both CRC flags
   a_crc_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
      (spi_crc_err_i |=> flags[F_SPI_CRC]) and (uart_crc_err_i |=> flags[F_UART_CRC]))
      else $error("CRC flag not latched");

   // RULE6: either port write error
   a_wr_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE6
      (spi_wr_addr_err_i || uart_wr_addr_err_i) |=> flags[F_WR_ADDR])
      else $error("write address error not latched");

   // RULE7: either port read error
   a_rd_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
      (spi_rd_addr_err_i || uart_rd_addr_err_i) |=> flags[F_RD_ADDR])
      else $error("read address error not latched");

   // RULE8: levels not latched
   a_ro_levels: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
      rd_hit |=> rd_data_o[25] == $past(spi_tx_empty_i) && rd_data_o[24] == $past(spi_rx_full_i))
      else $error("buffer level bits wrong");

   // RULE9: UART transmit overrun
   a_uart_tx_ovr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE9
      uart_tx_overrun_i |=> flags[F_UART_TX_OVR])
      else $error("UART transmit overrun not latched");

   // RULE10: UART receive overrun
   a_uart_rx_ovr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
      uart_rx_overrun_i |=> flags[F_UART_RX_OVR])
      else $error("UART receive overrun not latched");

   // RULE11: noise and framing
   a_noise_frame: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE11
      (uart_noise_i |=> flags[F_UART_NOISE]) and (uart_frame_i |=> flags[F_UART_FRAME]))
      else $error("noise or framing flag not latched");

   // RULE12: timeout flag
   a_timeout: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE12
      uart_timeout_i |=> flags[F_UART_TIMEOUT])
      else $error("timeout flag not latched");

   // RULE13: break flag
   a_break: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE13
      uart_break_i ##1 rd_hit |=> rd_data_o[16])
      else $error("break flag not shown");

   // RULE14: flag holds without clear
   a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE14
      (flags[F_SPI_CRC] && !(wr_hit && wr_data_i[28]))[*1] ##1 !wr_hit [*3]
      |-> flags[F_SPI_CRC])
      else $error("flag dropped without clear");

   // RULE14: set wins over clear
   a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE14
      (wr_hit && wr_data_i[21] && uart_rx_overrun_i) |=> flags[F_UART_RX_OVR])
      else $error("event lost during clear");

   // RULE15: clear by write
   a_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
      (wr_hit && wr_data_i[27] && !spi_wr_addr_err_i && !uart_wr_addr_err_i)
      |=> !flags[F_WR_ADDR])
      else $error("write did not clear flag");

   // RULE16: reserved mask bits
   a_mask_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE16
      wr_hit |=> mask == ($past(wr_data_i[15:0]) & 16'h7F7E) && !mask[0] && !mask[7])
      else $error("mask write wrong");

   // RULE17: break never interrupts
   a_break_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE17
      (status == 16'h0001) |=> !irq_out_a_o)
      else $error("break caused interrupt");

   // RULE3: overrun flag latched
   a_spi_rx_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
      spi_rx_overrun_i |=> flags[F_SPI_RX_OVR])
      else $error("SPI receive overrun not latched");

   // RULE13: break flag latched
   a_break_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE13
      uart_break_i |=> flags[F_UART_BREAK])
      else $error("break flag not latched");

   // RULE2: pins always equal
   a_pins_equal: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
      irq_out_a_o == irq_out_b_o)
      else $error("interrupt pins differ");

   // RULE17: no cause, no interrupt
   a_irq_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE17
      !(|(status & mask)) |=> !irq_out_a_o && !irq_out_b_o)
      else $error("interrupt without cause");

   // RULE1: every read answered
   a_read_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
      rd_en_i |=> rd_valid_o)
      else $error("read not answered");

   // RULE1: other read gives zero
   a_other_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
      (rd_en_i && rd_addr_i != REG_ADDR) |=> rd_data_o == 32'h00000000)
      else $error("unmapped read not zero");

   // RULE1: other write ignored
   a_other_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
      (wr_en_i && wr_addr_i != REG_ADDR) |=> mask == $past(mask))
      else $error("unmapped write changed mask");

   // RULE1: idle read port quiet
   a_read_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
      !rd_en_i |=> rd_data_o == 32'h00000000 && !rd_valid_o)
      else $error("read port not idle");

   // RULE16: reserved mask bits zero
   a_mask_rsvd: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE16
      !mask[15] && !mask[7] && !mask[0])
      else $error("reserved mask bit set");

   // RULE8: levels never stored
   a_ro_unlatched: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
      (flags & FLAG_RO_BITS) == 16'h0000)
      else $error("buffer level latched");

   // RULE14: noise flag holds
   a_sticky_noise: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE14
      (flags[F_UART_NOISE] && !(wr_hit && wr_data_i[20])) |=> flags[F_UART_NOISE])
      else $error("noise flag dropped");

   // RULE15: noise flag cleared
   a_clear_noise: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
      (wr_hit && wr_data_i[20] && !uart_noise_i) |=> !flags[F_UART_NOISE])
      else $error("noise flag not cleared");

   // RULE15: underrun flag cleared
   a_clear_und: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
      (wr_hit && wr_data_i[29] && !spi_tx_underrun_i) |=> !flags[F_SPI_TX_UND])
      else $error("underrun flag not cleared");

endmodule // serial_port_event_irq

// ---- verification/host_master_model.sv ----
// Purpose: Host master model for the event word
// Assumes: Requests launched by NBA at the rising edge
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ps
module host_master_model (
   // Clock
   input wire logic clk_i,
   // Register port
   output logic wr_en_o,
   output logic [6:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic rd_en_o,
   output logic [6:0] rd_addr_o,
   input wire logic [31:0] rd_data_i,
   input wire logic rd_valid_i
);
   initial begin
      wr_en_o = 1'b0;
      wr_addr_o = 7'h00;
      wr_data_o = 32'h0;
      rd_en_o = 1'b0;
      rd_addr_o = 7'h00;
   end
   task automatic write_word(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      wr_addr_o <= a;
      wr_data_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      wr_addr_o <= ~a;
      wr_data_o <= ~d;
   endtask
   task automatic read_word(input logic [6:0] a, output logic [31:0] d, output logic v);
      @(posedge clk_i);
      rd_en_o <= 1'b1;
      rd_addr_o <= a;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      rd_addr_o <= ~a;
      #1;
      d = rd_data_i;
      v = rd_valid_i;
   endtask
endmodule // host_master_model

// ---- verification/serial_port_event_irq_test.sv ----
// Purpose: Self-checking bench for the event flag block
// Assumes: Host model drives the register port
// Notes: ev bit k feeds flag k; bits 7, 15 feed UART address errors
`timescale 1ns/1ps
module serial_port_event_irq_test;
   import serial_irq_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [15:0] ev = 16'h0;
   logic wr_en, rd_en, rd_valid, irq_a, irq_b;
   logic [6:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   int error_cnt = 0;
   int checks = 0;
   always #10 clk_i = ~clk_i;
   host_master_model host_master_model_inst (.clk_i(clk_i), .wr_en_o(wr_en),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
      .rd_data_i(rd_data), .rd_valid_i(rd_valid));
   serial_port_event_irq serial_port_event_irq_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_en_i(rd_en),
      .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .spi_rx_overrun_i(ev[14]), .spi_tx_underrun_i(ev[13]), .spi_crc_err_i(ev[12]),
      .spi_wr_addr_err_i(ev[11]), .spi_rd_addr_err_i(ev[10]), .spi_tx_empty_i(ev[9]),
      .spi_rx_full_i(ev[8]), .uart_wr_addr_err_i(ev[7]), .uart_rd_addr_err_i(ev[15]),
      .uart_tx_overrun_i(ev[6]), .uart_rx_overrun_i(ev[5]), .uart_noise_i(ev[4]),
      .uart_frame_i(ev[3]), .uart_timeout_i(ev[2]), .uart_crc_err_i(ev[1]),
      .uart_break_i(ev[0]), .irq_out_a_o(irq_a), .irq_out_b_o(irq_b));
   task automatic stop_test();
      if (error_cnt == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic v;
      host_master_model_inst.read_word(a, d, v);
      chk({31'h0, v}, 32'h1);
      chk(d, exp);
   endtask
   task automatic pulse(input int k);
      @(posedge clk_i);
      ev[k] <= 1'b1;
      @(posedge clk_i);
      ev[k] <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task automatic test_events();
      int f;
      for (int k = 0; k < 16; k++) begin
         if (k == 8 || k == 9) continue;
         f = (k == 7) ? F_WR_ADDR : (k == 15) ? F_RD_ADDR : k;
         pulse(k);
         rd_chk(REG_ADDR, 32'h1 << (f + FLAG_LSB));
         host_master_model_inst.write_word(REG_ADDR, 32'h1 << (f + FLAG_LSB));
         rd_chk(REG_ADDR, 32'h0);
      end
   endtask
   task automatic test_mask();
      host_master_model_inst.write_word(REG_ADDR, 32'h0000FFFF);
      rd_chk(REG_ADDR, 32'h00007F7E);
      pulse(0);
      chk({30'h0, irq_a, irq_b}, 32'h0);
      rd_chk(REG_ADDR, 32'h00017F7E);
      pulse(4);
      chk({30'h0, irq_a, irq_b}, 32'h3);
      host_master_model_inst.write_word(REG_ADDR, 32'hFFFF7F7E);
      repeat (2) @(posedge clk_i);
      #1;
      chk({30'h0, irq_a, irq_b}, 32'h0);
      @(posedge clk_i);
      ev[9:8] <= 2'b11;
      rd_chk(REG_ADDR, 32'h03007F7E);
      chk({30'h0, irq_a, irq_b}, 32'h3);
      @(posedge clk_i);
      ev[9:8] <= 2'b00;
      rd_chk(REG_ADDR, 32'h00007F7E);
   endtask
   task automatic test_set_wins();
      @(posedge clk_i);
      ev[5] <= 1'b1;
      host_master_model_inst.write_word(REG_ADDR, 32'h00207F7E);
      ev[5] <= 1'b0;
      rd_chk(REG_ADDR, 32'h00207F7E);
      host_master_model_inst.write_word(REG_ADDR, 32'h00207F7E);
      rd_chk(REG_ADDR, 32'h00007F7E);
   endtask
   task automatic test_reset();
      pulse(4);
      chk({30'h0, irq_a, irq_b}, 32'h3);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk({30'h0, irq_a, irq_b}, 32'h0);
      chk(rd_data, RD_RESET);
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd_chk(REG_ADDR, RD_RESET);
   endtask
   task automatic test_unmapped();
      host_master_model_inst.write_word(7'h27, 32'hFFFFFFFF);
      rd_chk(REG_ADDR, 32'h00007F7E);
      rd_chk(7'h29, 32'h0);
   endtask
   initial begin
      #100000;
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd_chk(REG_ADDR, RD_RESET);
      test_events();
      test_mask();
      test_set_wins();
      test_unmapped();
      test_reset();
      stop_test();
   end
endmodule // serial_port_event_irq_test
